// ### terminal_register_access_port_tb_top.sv
// self-checking bench: apb commands through the coupler to the terminal
`timescale 1ns/100ps
`include "trap_consts.svh"
module terminal_register_access_port_tb_top;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        pready;
   logic        pslverr;
   logic [31:0] prdata;
   logic [7:0]  pd_ctrl;
   logic        pd_strobe;
   logic [15:0] pd_out_word;
   logic [15:0] feature_active;
   logic        write_unlocked;
   logic [31:0] rd;
   logic        err;
   int          err_count = 0;
   int          n_checks = 0;
   int          cycles = 0;
   int          n_pd = 0;
   trap_link_if link ();
   trap_coupler trap_coupler_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .pslverr(pslverr), .prdata(prdata), .link(link));
   // pd inputs fixed: 0x3c tells a process data answer from any receipt
   trap_terminal trap_terminal_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1),
      .link(link), .pd_status(8'h3c), .pd_in_word(16'hbeef), .pd_strobe(pd_strobe),
      .pd_ctrl(pd_ctrl), .pd_out_word(pd_out_word), .feature_active(feature_active),
      .write_unlocked(write_unlocked));
   trap_link_monitor trap_link_monitor_inst (.pclk(pclk), .presetn(presetn),
      .req_valid(link.req_valid), .req_ctrl(link.req_ctrl), .req_hi(link.req_hi),
      .req_lo(link.req_lo), .rsp_valid(link.rsp_valid), .rsp_stat(link.rsp_stat),
      .rsp_hi(link.rsp_hi), .rsp_lo(link.rsp_lo));
   always #25 pclk = ~pclk;
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (pd_strobe === 1'b1) begin
         n_pd++;
      end
      if (cycles == 20000) begin
         err_count++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one idle edge before setup keeps psel from being assigned twice
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // pready and read data are taken at the same rising edge
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic op(input logic [7:0] c, input logic [15:0] w,
                     input logic [7:0] st, input logic [15:0] dat);
      apb(1'b1, `TRAP_APB_CMD, {w, 8'h00, c});
      rd = 32'h0;
      while (rd[`TRAP_STAT_DONE] !== 1'b1) apb(1'b0, `TRAP_APB_STAT, 32'h0);
      chk(rd, {16'h0000, st, 8'h02});
      if (c[7:6] != 2'b11) begin
         apb(1'b0, `TRAP_APB_RDATA, 32'h0);
         chk(rd, {16'h0000, dat});
      end
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      op(8'h80, 16'hffff, 8'h80, `TRAP_TYPE_CODE);
      op(8'he0, 16'h0002, 8'ha0, 16'h0000);
      op(8'ha0, 16'h0000, 8'ha0, 16'h0000);
      op(8'hdf, 16'h1235, 8'h9f, 16'h0000);
      chk({31'h0, write_unlocked}, 32'h1);
      op(8'h9f, 16'hffff, 8'h9f, 16'h1235);
      op(8'he0, 16'h0002, 8'ha0, 16'h0000);
      apb(1'b0, `TRAP_APB_RDATA, 32'h0);
      chk(rd, 32'h1235);
      op(8'ha0, 16'h0000, 8'ha0, 16'h0002);
      chk({16'h0000, feature_active}, 32'h0);
      op(8'hc5, 16'h7777, 8'h85, 16'h0000);
      op(8'h85, 16'h0000, 8'h85, 16'h0000);
      op(8'hdf, 16'h0001, 8'h9f, 16'h0000);
      chk({31'h0, write_unlocked}, 32'h0);
      op(8'he1, 16'h7777, 8'ha1, 16'h0000);
      op(8'ha1, 16'h0000, 8'ha1, 16'h0000);
      op(8'hdf, 16'h1235, 8'h9f, 16'h0000);
      op(8'hdf, 16'h0000, 8'h9f, 16'h0000);
      chk({31'h0, write_unlocked}, 32'h0);
      chk(n_pd, 32'h0);
      op(8'h05, 16'h4321, 8'h3c, 16'hbeef);
      chk(n_pd, 32'h1);
      chk({24'h0, pd_ctrl}, 32'h05);
      chk({16'h0000, pd_out_word}, 32'h4321);
      apb(1'b0, 12'h00c, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      final_report();
   end
endmodule

// ### trap_consts.svh
// constants for the terminal register access port and its coupler end
`ifndef TRAP_CONSTS_SVH
`define TRAP_CONSTS_SVH

// control / status byte layout
`define TRAP_CTRL_REG_BIT     7
`define TRAP_CTRL_WR_BIT      6
`define TRAP_ADDR_MSB         5
`define TRAP_ADDR_W           6
`define TRAP_NUM_REGS         64

// register numbers
`define TRAP_REG_UNLOCK       6'h1f
`define TRAP_REG_FEATURE      6'h20
`define TRAP_REG_TYPE         6'h00
`define TRAP_FIRST_USER_REG   6'h1f

// register values
`define TRAP_UNLOCK_CODE      16'h1235
`define TRAP_LOCK_CODE        16'h0000
`define TRAP_FEATURE_RST      16'h0000
`define TRAP_TYPE_CODE        16'h5a5a

// coupler apb register offsets
`define TRAP_APB_CMD          12'h000
`define TRAP_APB_STAT         12'h004
`define TRAP_APB_RDATA        12'h008

// coupler status register fields
`define TRAP_STAT_BUSY        0
`define TRAP_STAT_DONE        1
`define TRAP_STAT_RCPT_ERR    2
`define TRAP_STAT_BYTE_LSB    8

`endif

// ### trap_coupler.sv
// coupler end: apb command registers driving the process image link
`timescale 1ns/100ps
`include "trap_consts.svh"
module trap_coupler (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // process image link
   trap_link_if.host        link
);

   trap_pkg::trap_host_s s_q;
   trap_pkg::trap_host_s s_d;

   logic       acc;
   logic       hit;
   logic [7:0] expect_stat;

   assign acc = psel && penable;
   assign hit = (paddr == `TRAP_APB_CMD) || (paddr == `TRAP_APB_STAT) ||
                (paddr == `TRAP_APB_RDATA);

   // a write receipt has the direction bit cleared, a read echoes
   assign expect_stat = s_q.req_ctrl[`TRAP_CTRL_WR_BIT] ?
                        (s_q.req_ctrl & ~(8'h01 << `TRAP_CTRL_WR_BIT)) :
                        s_q.req_ctrl;

   always_comb begin
      s_d           = s_q;
      s_d.req_valid = 1'b0;
      s_d.pready    = 1'b0;
      s_d.pslverr   = 1'b0;

      // one wait state so that prdata can come from a flop
      if (acc && !s_q.pready) begin
         s_d.pready  = 1'b1;
         s_d.pslverr = !hit;
         s_d.prdata  = 32'h0000_0000;
         if (!pwrite) begin
            unique case (paddr)
               `TRAP_APB_STAT: begin
                  s_d.prdata[`TRAP_STAT_BUSY]     = (s_q.st == trap_pkg::TRAP_WAIT);
                  s_d.prdata[`TRAP_STAT_DONE]     = s_q.done;
                  s_d.prdata[`TRAP_STAT_RCPT_ERR] = s_q.rcpt_err;
                  s_d.prdata[`TRAP_STAT_BYTE_LSB +: 8] = s_q.last_stat;
               end
               `TRAP_APB_RDATA: begin
                  s_d.prdata[15:0] = s_q.rdata;
               end
               default: begin
                  s_d.prdata = 32'h0000_0000;
               end
            endcase
         end
      end

      // command taken at the completing edge; refused while busy
      if (acc && s_q.pready && pwrite && (paddr == `TRAP_APB_CMD) &&
          (s_q.st == trap_pkg::TRAP_IDLE)) begin
         s_d.req_valid = 1'b1;
         s_d.req_ctrl  = pwdata[7:0];
         s_d.req_data  = pwdata[31:16];
         s_d.done      = 1'b0;
         s_d.rcpt_err  = 1'b0;
         s_d.st        = trap_pkg::TRAP_WAIT;
      end

      if ((s_q.st == trap_pkg::TRAP_WAIT) && link.rsp_valid) begin
         s_d.st        = trap_pkg::TRAP_IDLE;
         s_d.done      = 1'b1;
         s_d.last_stat = link.rsp_stat;
         s_d.rcpt_err  = s_q.req_ctrl[`TRAP_CTRL_REG_BIT] &&
                         (link.rsp_stat != expect_stat);
         // input word after a register write is meaningless
         if (!(s_q.req_ctrl[`TRAP_CTRL_REG_BIT] &&
               s_q.req_ctrl[`TRAP_CTRL_WR_BIT])) begin
            s_d.rdata = {link.rsp_hi, link.rsp_lo};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q    <= '0;
         s_q.st <= trap_pkg::TRAP_IDLE;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign pready         = s_q.pready;
   assign pslverr        = s_q.pslverr;
   assign prdata         = s_q.prdata;
   assign link.req_valid = s_q.req_valid;
   assign link.req_ctrl  = s_q.req_ctrl;
   assign link.req_hi    = s_q.req_data[15:8];
   assign link.req_lo    = s_q.req_data[7:0];

endmodule

// ### trap_link_if.sv
// process image link between coupler end and terminal end
`timescale 1ns/100ps
interface trap_link_if;
   // coupler to terminal
   logic       req_valid;
   logic [7:0] req_ctrl;
   logic [7:0] req_hi;
   logic [7:0] req_lo;
   // terminal to coupler
   logic       rsp_valid;
   logic [7:0] rsp_stat;
   logic [7:0] rsp_hi;
   logic [7:0] rsp_lo;

   modport dev  (input req_valid, req_ctrl, req_hi, req_lo,
                 output rsp_valid, rsp_stat, rsp_hi, rsp_lo);
   modport host (output req_valid, req_ctrl, req_hi, req_lo,
                 input rsp_valid, rsp_stat, rsp_hi, rsp_lo);
endinterface

// ### trap_link_monitor.sv
// concurrent checks on the process image link between coupler and terminal
`timescale 1ns/100ps
`include "trap_consts.svh"
module trap_link_monitor (
   // clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // coupler to terminal
   input wire logic       req_valid,
   input wire logic [7:0] req_ctrl,
   input wire logic [7:0] req_hi,
   input wire logic [7:0] req_lo,
   // terminal to coupler
   input wire logic       rsp_valid,
   input wire logic [7:0] rsp_stat,
   input wire logic [7:0] rsp_hi,
   input wire logic [7:0] rsp_lo
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic        wr_reg;
   logic [15:0] code_q;
   logic [15:0] feat_q;
   assign wr_reg = req_valid && req_ctrl[7:6] == 2'b11;
   // shadow of the code and feature registers, assumes ce held high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_q <= 16'h0000;
         feat_q <= 16'h0000;
      end else begin
         if (wr_reg && req_ctrl[5:0] == `TRAP_REG_UNLOCK) code_q <= {req_hi, req_lo};
         if (wr_reg && req_ctrl[5:0] == `TRAP_REG_FEATURE && code_q == `TRAP_UNLOCK_CODE)
            feat_q <= {req_hi, req_lo};
      end
   end
   rsp_timing_a: assert property (req_valid |=> rsp_valid)
      else $error("no answer one cycle after request");
   rsp_cause_a: assert property (rsp_valid |-> $past(req_valid))
      else $error("answer without request");
   wr_rcpt_a: assert property (wr_reg |=> rsp_stat == ($past(req_ctrl) & 8'hbf))
      else $error("bad write receipt");
   rd_rcpt_a: assert property (req_valid && req_ctrl[7:6] == 2'b10 |=>
      rsp_stat == $past(req_ctrl)) else $error("bad read receipt");
   code_read_a: assert property (req_valid && req_ctrl == 8'h9f |=>
      {rsp_hi, rsp_lo} == $past(code_q)) else $error("bad code word read");
   feat_read_a: assert property (req_valid && req_ctrl == 8'ha0 |=>
      {rsp_hi, rsp_lo} == $past(feat_q)) else $error("bad feature word read");
   low_reg_a: assert property (req_valid && req_ctrl[7:6] == 2'b10 &&
      req_ctrl[5:0] inside {[1:30]} |=> {rsp_hi, rsp_lo} == 16'h0000)
      else $error("read-only register changed");
   rsp_hold_a: assert property (!rsp_valid |-> $stable({rsp_stat, rsp_hi, rsp_lo}))
      else $error("answer bytes moved without answer");
   cover property (req_valid && req_ctrl == 8'hdf && {req_hi, req_lo} == `TRAP_UNLOCK_CODE);
   cover property (wr_reg && req_ctrl[5:0] == `TRAP_REG_FEATURE && code_q == `TRAP_UNLOCK_CODE);
   cover property (req_valid && !req_ctrl[7]);
endmodule

// ### trap_pkg.sv
// types shared by both ends of the terminal register access port
package trap_pkg;

   typedef logic [7:0]  trap_byte_t;
   typedef logic [15:0] trap_word_t;

   typedef enum logic {
      TRAP_IDLE,
      TRAP_WAIT
   } trap_host_e;

   typedef struct packed {
      logic              unlocked;
      logic              loaded;
      trap_word_t        feat_act;
      logic              rsp_valid;
      trap_byte_t        rsp_stat;
      trap_word_t        rsp_data;
      logic              pd_strobe;
      trap_byte_t        pd_ctrl;
      trap_word_t        pd_word;
   } trap_dev_s;

   typedef struct packed {
      trap_host_e        st;
      logic              req_valid;
      trap_byte_t        req_ctrl;
      trap_word_t        req_data;
      logic              done;
      logic              rcpt_err;
      trap_byte_t        last_stat;
      trap_word_t        rdata;
      logic              pready;
      logic              pslverr;
      logic [31:0]       prdata;
   } trap_host_s;

endpackage

// ### trap_terminal.sv
// terminal end: register set reached through the cyclic process image
// Behaviour
// - control bit 7 selects register access
// - bit 6 set writes output word
// - bit 6 clear reads, contents unchanged
// - six low control bits address register
// - write receipt is control with bit 6 cleared
// - read receipt equals the control byte
// - coupler ignores input word after writes
// - word high byte first, after control byte
// - code 0x1235 in register 31 unlocks
// - 0x0000 in register 31 relocks
// - reading register 31 returns code word
// - register 32 feature word read/write
// - output word ignored on reads
// - coupler sends value with write control
// - locked user registers except 31 read-only
// - any other code relocks
// - changes take effect after restart only; here reset also clears the stored word
`timescale 1ns/100ps
`include "trap_consts.svh"
module trap_terminal (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // process image link
   trap_link_if.dev         link,
   // process data from the terminal's own function
   input  wire logic [7:0]  pd_status,
   input  wire logic [15:0] pd_in_word,
   // process data handed to the terminal's own function
   output logic             pd_strobe,
   output logic [7:0]       pd_ctrl,
   output logic [15:0]      pd_out_word,
   // register effects
   output logic [15:0]      feature_active,
   output logic             write_unlocked
);

   trap_pkg::trap_dev_s s_q;
   trap_pkg::trap_dev_s s_d;

   // user words 31..63 in flops; the words below read as constants
   trap_pkg::trap_word_t          user_q [`TRAP_FIRST_USER_REG:`TRAP_NUM_REGS-1];

   // decoded request fields
   logic                          reg_mode;
   logic                          wr_req;
   logic [`TRAP_ADDR_W-1:0]       addr;
   trap_pkg::trap_word_t          out_word;
   logic                          user_reg;
   logic                          wr_allowed;
   logic                          wr_take;
   logic                          unlock_hit;
   trap_pkg::trap_word_t          rd_word;
   trap_pkg::trap_byte_t          ans_stat;
   trap_pkg::trap_word_t          ans_word;

   assign reg_mode = link.req_ctrl[`TRAP_CTRL_REG_BIT];
   assign wr_req   = link.req_ctrl[`TRAP_CTRL_WR_BIT];
   assign addr     = link.req_ctrl[`TRAP_ADDR_MSB:0];
   assign out_word = {link.req_hi, link.req_lo};

   // registers below the user range are fixed, never writable
   assign user_reg = (addr >= `TRAP_FIRST_USER_REG);

   // register 31 stays writable so the unlock code can always be sent
   assign wr_allowed = user_reg &&
                       ((addr == `TRAP_REG_UNLOCK) || s_q.unlocked);

   // a word is stored only on an enabled edge with an allowed write
   assign wr_take = ce && link.req_valid && reg_mode && wr_req &&
                    wr_allowed;

   // only the exact code unlocks, anything else locks
   assign unlock_hit = (out_word == `TRAP_UNLOCK_CODE);

   // read mux: type code at 0, zeros up to 30, stored words above
   always_comb begin
      if (addr == `TRAP_REG_TYPE) begin
         rd_word = `TRAP_TYPE_CODE;
      end else if (!user_reg) begin
         rd_word = 16'h0000;
      end else begin
         rd_word = user_q[addr];
      end
   end

   // limitation: reset also clears the store, so a restart only ever
   // brings the reset value of the feature word into effect
   genvar gi;
   generate
      for (gi = `TRAP_FIRST_USER_REG; gi < `TRAP_NUM_REGS; gi++) begin : g_user
         localparam trap_pkg::trap_word_t rst_val =
            (6'(gi) == `TRAP_REG_FEATURE) ? `TRAP_FEATURE_RST : 16'h0000;
         logic hit;

         // word taken only when addressed and the write is allowed
         assign hit = wr_take && (addr == 6'(gi));

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               user_q[gi] <= rst_val;
            end else if (hit) begin
               user_q[gi] <= out_word;
            end
         end
      end
   endgenerate

   // receipt and answer word for the request now on the link;
   // the receipt never tells a refused write apart, so read back
   always_comb begin
      unique case ({reg_mode, wr_req})
         2'b11: begin
            // receipt is sent even when the write is refused
            ans_stat = link.req_ctrl & ~(8'h01 << `TRAP_CTRL_WR_BIT);
            // the word sent back after a write carries no meaning
            ans_word = rd_word;
         end
         2'b10: begin
            // output word is not looked at on a read
            ans_stat = link.req_ctrl;
            ans_word = rd_word;
         end
         default: begin
            // ordinary process data exchange, bit 6 has no meaning
            ans_stat = pd_status;
            ans_word = pd_in_word;
         end
      endcase
   end

   always_comb begin
      s_d           = s_q;
      s_d.rsp_valid = 1'b0;
      s_d.pd_strobe = 1'b0;

      // first enabled cycle after restart: the stored feature word becomes active
      if (!s_q.loaded) begin
         s_d.loaded   = 1'b1;
         s_d.feat_act = user_q[`TRAP_REG_FEATURE];
      end

      if (link.req_valid) begin
         s_d.rsp_valid = 1'b1;
         s_d.rsp_stat  = ans_stat;
         s_d.rsp_data  = ans_word;
         if (reg_mode) begin
            if (wr_req && (addr == `TRAP_REG_UNLOCK)) begin
               s_d.unlocked = unlock_hit;
            end
         end else begin
            s_d.pd_strobe = 1'b1;
            s_d.pd_ctrl   = link.req_ctrl;
            s_d.pd_word   = out_word;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q          <= '0;
         s_q.feat_act <= `TRAP_FEATURE_RST;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // link answers
   assign link.rsp_valid = s_q.rsp_valid;
   assign link.rsp_stat  = s_q.rsp_stat;
   assign link.rsp_hi    = s_q.rsp_data[15:8];
   assign link.rsp_lo    = s_q.rsp_data[7:0];

   // user side
   assign pd_strobe      = s_q.pd_strobe;
   assign pd_ctrl        = s_q.pd_ctrl;
   assign pd_out_word    = s_q.pd_word;
   assign feature_active = s_q.feat_act;
   assign write_unlocked = s_q.unlocked;

endmodule
